//--- rtl/ple_defines.svh
`ifndef PLE_DEFINES_SVH
`define PLE_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte addresses on the APB port)
// ----------------------------------------------------------------
`define PLE_ADDR_W 12
`define PLE_ADDR_CTRL 12'h000
`define PLE_ADDR_TRUTH 12'h004
`define PLE_ADDR_STATUS 12'h008

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PLE_CTRL_RST 32'h0000_03F0
`define PLE_TRUTH_RST 16'h0000
`define PLE_ZERO_WORD 32'h0000_0000

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PLE_TRUTH_W 16
`define PLE_STRB_W 4
`define PLE_SYNC_W 6

`endif

//--- rtl/ple_pkg.sv
package ple_pkg;

  // ----------------------------------------------------------------
  // Configuration enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLE_MODE_NORMAL = 2'b00,
    PLE_MODE_ARITH  = 2'b01,
    PLE_MODE_UPDN   = 2'b10,
    PLE_MODE_CLRCNT = 2'b11
  } ple_mode_t;

  typedef enum logic [1:0] {
    PLE_FF_D  = 2'b00,
    PLE_FF_T  = 2'b01,
    PLE_FF_JK = 2'b10,
    PLE_FF_SR = 2'b11
  } ple_ff_t;

  typedef enum logic [1:0] {
    PLE_SRC_GLOBAL = 2'b00,
    PLE_SRC_PIN    = 2'b01,
    PLE_SRC_INTERN = 2'b10,
    PLE_SRC_NONE   = 2'b11
  } ple_src_t;

  // Control register layout, bit 0 is mode[0]
  typedef struct packed {
    logic [12:0] pad;
    logic skip_out_en;
    logic skip_in_sel;
    logic chain_end;
    logic chain_start;
    logic route_sel;
    logic local_sel;
    logic casc_and;
    logic casc_en;
    logic ena_use;
    ple_src_t pre_src;
    ple_src_t clr_src;
    ple_src_t clk_src;
    ple_ff_t ff_type;
    ple_mode_t mode;
  } ple_ctrl_t;

  // Register control triple from one source kind
  typedef struct packed {
    logic clk;
    logic clr;
    logic pre;
  } ple_ctl_t;

  // Chain links to and from neighbouring elements
  typedef struct packed {
    logic carry;
    logic cascade;
    logic carry_skip;
  } ple_chain_t;

endpackage : ple_pkg

//--- rtl/ple_sync.sv
`timescale 1ns/1ps
`include "ple_defines.svh"

module ple_sync import ple_pkg::*; #(
  parameter int W = `PLE_SYNC_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels from outside the clock domain
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : ple_sync

//--- rtl/ple_lut.sv
`timescale 1ns/1ps
`include "ple_defines.svh"

module ple_lut import ple_pkg::*; (
  // Truth table and select
  input wire logic [`PLE_TRUTH_W-1:0] truth,
  input wire logic [3:0] idx,
  // Result
  output logic f
);

  logic [`PLE_TRUTH_W-1:0] hit;

  // One-hot entry match, then OR; keeps the mux flat and even
  genvar i;
  generate
    for (i = 0; i < `PLE_TRUTH_W; i++) begin : g_entry
      assign hit[i] = truth[i] & (idx == 4'(i));
    end
  endgenerate

  assign f = |hit;

endmodule : ple_lut

//--- rtl/ple_top.sv
`timescale 1ns/1ps
`include "ple_defines.svh"

//Contract
// - Register acts as D, T, JK or SR
// - Clock, clear, preset from global, pin, internal
// - Combinational use bypasses register, table drives output
// - Two outputs, each selects table or register
// - Carry input feeds table and next carry
// - Carry and cascade link elements in sequence
// - Long carry skips to block two ahead
// - Carry chain stops and restarts at memory
// - Exactly four configured operating modes
// - Seven inputs routed to mode-dependent destinations
// - Separate clock, clear and preset register inputs
// - Synchronous clock enable from first data input
// - Cascade builds wide functions without local routing
module ple_top import ple_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PLE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [`PLE_STRB_W-1:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data inputs from local interconnect
  input wire logic [3:0] data_in,
  // Register controls, three source kinds
  input wire ple_ctl_t glb_ctl,
  input wire ple_ctl_t pin_ctl,
  input wire ple_ctl_t int_ctl,
  // Chain links from previous element
  input wire ple_chain_t chain_in,
  // Chain links to next element
  output ple_chain_t chain_out,
  // Element outputs
  output logic local_out,
  output logic route_out
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  ple_ctrl_t ctrl;
  logic [`PLE_TRUTH_W-1:0] truth;
  logic [31:0] ctrl_word;
  logic [31:0] truth_word;
  logic [31:0] status_word;
  logic [31:0] next_ctrl;
  logic [31:0] next_truth;
  logic wr_acc;
  logic hit;
  logic q;

  assign wr_acc = psel && penable && pwrite;
  assign ctrl_word = ctrl;
  assign truth_word = {16'h0000, truth};
  assign hit = (paddr == `PLE_ADDR_CTRL) || (paddr == `PLE_ADDR_TRUTH) ||
               (paddr == `PLE_ADDR_STATUS);

  // Byte lanes merge under pstrb
  genvar b;
  generate
    for (b = 0; b < `PLE_STRB_W; b++) begin : g_lane
      assign next_ctrl[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : ctrl_word[b*8 +: 8];
      assign next_truth[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : truth_word[b*8 +: 8];
    end
  endgenerate

  // Writes land at the access edge; pad bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ple_ctrl_t'(`PLE_CTRL_RST);
    end else if (wr_acc && paddr == `PLE_ADDR_CTRL) begin
      ctrl <= ple_ctrl_t'({13'h0000, next_ctrl[18:0]});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      truth <= `PLE_TRUTH_RST;
    end else if (wr_acc && paddr == `PLE_ADDR_TRUTH) begin
      truth <= next_truth[`PLE_TRUTH_W-1:0];
    end
  end

  // Read data captured in setup so it is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PLE_ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PLE_ADDR_CTRL: prdata <= ctrl_word;
        `PLE_ADDR_TRUTH: prdata <= truth_word;
        `PLE_ADDR_STATUS: prdata <= status_word;
        default: prdata <= `PLE_ZERO_WORD;
      endcase
    end
  end

  // Zero wait states; unmapped address answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------------
  // Control source selection
  // ----------------------------------------------------------------
  logic [`PLE_SYNC_W-1:0] ext_sync;
  ple_ctl_t glb_s;
  ple_ctl_t pin_s;
  logic clk_lvl;
  logic clk_prev;
  logic clr_act;
  logic pre_act;
  logic clk_rise;
  logic tick;

  // Global and pin controls come from outside the domain
  ple_sync #(.W(`PLE_SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({glb_ctl, pin_ctl}),
    .sync_out(ext_sync)
  );

  assign glb_s = ext_sync[5:3];
  assign pin_s = ext_sync[2:0];

  function automatic logic pick(input ple_src_t s, input logic g, input logic p,
                                input logic i);
    case (s)
      PLE_SRC_GLOBAL: pick = g;
      PLE_SRC_PIN: pick = p;
      PLE_SRC_INTERN: pick = i;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  // Each control chooses its own source kind
  assign clk_lvl = pick(ctrl.clk_src, glb_s.clk, pin_s.clk, int_ctl.clk);
  assign clr_act = pick(ctrl.clr_src, glb_s.clr, pin_s.clr, int_ctl.clr);
  assign pre_act = pick(ctrl.pre_src, glb_s.pre, pin_s.pre, int_ctl.pre);

  // Source clock seen as a rising-edge enable on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_lvl;
    end
  end

  assign clk_rise = clk_lvl && !clk_prev;
  // First data input gates the load when enabled
  assign tick = clk_rise && (!ctrl.ena_use || data_in[0]);

  // ----------------------------------------------------------------
  // Lookup table and carry
  // ----------------------------------------------------------------
  logic cin;
  logic [3:0] idx_a;
  logic [3:0] idx_b;
  logic f_a;
  logic f_b;
  logic is_arith;
  logic comb;
  logic carry_nx;

  // Start of chain ignores the incoming carry; skip link optional
  assign cin = ctrl.chain_start ? 1'b0 :
               (ctrl.skip_in_sel ? chain_in.carry_skip : chain_in.carry);
  assign is_arith = (ctrl.mode != PLE_MODE_NORMAL);

  // Mode steers the seven inputs into the table
  always_comb begin
    idx_a = data_in;
    idx_b = 4'h0;
    case (ctrl.mode)
      PLE_MODE_NORMAL: begin
        idx_a = data_in;
      end
      PLE_MODE_ARITH: begin
        idx_a = {1'b0, data_in[0], data_in[1], cin};
        idx_b = {1'b1, data_in[0], data_in[1], cin};
      end
      PLE_MODE_UPDN, PLE_MODE_CLRCNT: begin
        idx_a = {1'b0, data_in[2], q, cin};
        idx_b = {1'b1, data_in[2], q, cin};
      end
      default: begin
        idx_a = data_in;
      end
    endcase
  end

  // Low half gives sum, high half gives carry in split modes
  ple_lut u_lut_a (
    .truth(truth),
    .idx(idx_a),
    .f(f_a)
  );

  ple_lut u_lut_b (
    .truth(truth),
    .idx(idx_b),
    .f(f_b)
  );

  // Carry forward; normal mode passes it straight on
  assign carry_nx = is_arith ? f_b : cin;

  // Cascade joins the neighbour's result without local routing
  always_comb begin
    comb = f_a;
    if (ctrl.casc_en) begin
      comb = ctrl.casc_and ? (f_a & chain_in.cascade) : (f_a | chain_in.cascade);
    end
  end

  // Chain end blocks carry at the memory block boundary
  assign chain_out.carry = ctrl.chain_end ? 1'b0 : carry_nx;
  assign chain_out.cascade = comb;
  assign chain_out.carry_skip = (ctrl.skip_out_en && !ctrl.chain_end) ? carry_nx : 1'b0;

  // ----------------------------------------------------------------
  // Programmable register
  // ----------------------------------------------------------------
  logic next_q;

  // Counter modes load plainly; the flip-flop kind applies otherwise
  always_comb begin
    next_q = q;
    case (ctrl.mode)
      PLE_MODE_UPDN: begin
        next_q = data_in[3] ? data_in[1] : f_a;
      end
      PLE_MODE_CLRCNT: begin
        next_q = data_in[3] ? 1'b0 : f_a;
      end
      default: begin
        case (ctrl.ff_type)
          PLE_FF_D: next_q = comb;
          PLE_FF_T: next_q = q ^ comb;
          PLE_FF_JK: next_q = (comb && !q) || (!data_in[3] && q);
          PLE_FF_SR: begin
            // Both set and reset high holds the state
            if (comb && !data_in[3]) begin
              next_q = 1'b1;
            end else if (data_in[3] && !comb) begin
              next_q = 1'b0;
            end else begin
              next_q = q;
            end
          end
          default: next_q = q;
        endcase
      end
    endcase
  end

  // Clear beats preset beats clock; all sampled on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (clr_act) begin
      q <= 1'b0;
    end else if (pre_act) begin
      q <= 1'b1;
    end else if (tick) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and status
  // ----------------------------------------------------------------
  // Each output picks on its own, so table and register can differ
  assign local_out = ctrl.local_sel ? q : comb;
  assign route_out = ctrl.route_sel ? q : comb;

  assign status_word = {26'h0000000, chain_out.carry_skip, chain_out.carry, f_b, f_a,
                        comb, q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clear_wins: assert property (clr_act |=> !q)
    else $error("clear did not zero the register");
  a_preset_sets: assert property (pre_act && !clr_act |=> q)
    else $error("preset did not set the register");
  a_enable_hold: assert property (ctrl.ena_use && !data_in[0] && !clr_act && !pre_act
                                  |=> $stable(q))
    else $error("register loaded with enable low");
  a_dff_load: assert property (tick && !clr_act && !pre_act && ctrl.ff_type == PLE_FF_D
                               && ctrl.mode == PLE_MODE_NORMAL |=> q == $past(comb))
    else $error("D load mismatch");
  a_toggle_flip: assert property (tick && !clr_act && !pre_act && comb
                                  && ctrl.ff_type == PLE_FF_T && ctrl.mode == PLE_MODE_NORMAL
                                  |=> q != $past(q))
    else $error("T register did not toggle");
  a_bypass_path: assert property (!ctrl.local_sel && !ctrl.casc_en |-> local_out == f_a)
    else $error("bypass output differs from table");
  a_carry_pass: assert property (ctrl.mode == PLE_MODE_NORMAL && !ctrl.chain_start
                                 && !ctrl.chain_end && !ctrl.skip_in_sel
                                 |-> chain_out.carry == chain_in.carry)
    else $error("carry not forwarded");
  a_chain_stop: assert property (ctrl.chain_end |-> !chain_out.carry && !chain_out.carry_skip)
    else $error("carry leaked past chain end");
  a_casc_and: assert property (ctrl.casc_en && ctrl.casc_and && !chain_in.cascade
                               |-> !chain_out.cascade)
    else $error("AND cascade passed a one");
  a_ctrl_write: assert property (wr_acc && paddr == `PLE_ADDR_CTRL && pstrb == 4'hF
                                 |=> ctrl_word[18:0] == $past(pwdata[18:0]))
    else $error("control write lost");
  // Counter modes and SR hold are easy to break when decode changes
  a_hold_idle: assert property (!tick && !clr_act && !pre_act |=> $stable(q))
    else $error("register moved without clock, clear or preset");
  a_sr_hold: assert property (tick && !clr_act && !pre_act && comb && data_in[3]
                              && ctrl.ff_type == PLE_FF_SR && ctrl.mode == PLE_MODE_NORMAL
                              |=> $stable(q))
    else $error("SR register moved with set and reset high");
  a_updn_load: assert property (tick && !clr_act && !pre_act && data_in[3]
                                && ctrl.mode == PLE_MODE_UPDN
                                |=> q == $past(data_in[1]))
    else $error("up/down counter load mismatch");
  a_clrcnt_zero: assert property (tick && !clr_act && !pre_act && data_in[3]
                                  && ctrl.mode == PLE_MODE_CLRCNT |=> !q)
    else $error("clearable counter did not clear");

  c_tick_load: cover property (tick && !clr_act && !pre_act);
  c_arith_carry: cover property (ctrl.mode == PLE_MODE_ARITH && chain_out.carry);
  // Ticks need the source clock low in between, so never back to back
  c_count_step: cover property (ctrl.mode == PLE_MODE_UPDN && tick ##[2:4] tick);
  c_pack_split: cover property (ctrl.local_sel != ctrl.route_sel && local_out != route_out);

endmodule : ple_top

//--- tb/ple_nbr.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Previous element and block two back, seen from the chain inputs
// ----------------------------------------------------------------
module ple_nbr import ple_pkg::*; (
  // Value the neighbours are to present
  input wire ple_chain_t want,
  // Chain links into the element under test
  output ple_chain_t chain
);
  // Neighbour outputs are lookup results, so they follow at once
  assign chain = want;
endmodule : ple_nbr

//--- tb/tb.sv
`timescale 1ns/1ps
`include "ple_defines.svh"

module tb import ple_pkg::*;;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] data_in = 4'h0;
  ple_ctl_t glb_ctl = '0;
  ple_ctl_t pin_ctl = '0;
  ple_ctl_t int_ctl = '0;
  ple_chain_t want = '0;
  ple_chain_t lnk = '0;
  ple_chain_t chain_in;
  ple_chain_t chain_out;
  logic [31:0] prdata;
  logic pready, pslverr, local_out, route_out;
  logic [31:0] rd;
  logic err;
  logic [15:0] tt;
  ple_ctrl_t cfg;
  int n_errors = 0;
  int comparisons = 0;

  // 25 MHz clock
  always #20 pclk = ~pclk;

  ple_nbr u_nbr (.want(want), .chain(chain_in));

  ple_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_in(data_in), .glb_ctl(glb_ctl),
    .pin_ctl(pin_ctl), .int_ctl(int_ctl), .chain_in(chain_in), .chain_out(chain_out),
    .local_out(local_out), .route_out(route_out));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; waits on pready rather than assuming zero wait states
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wcfg;
    apb(1'b1, `PLE_ADDR_CTRL, cfg);
  endtask : wcfg

  task automatic wtt(input logic [15:0] t);
    tt = t;
    apb(1'b1, `PLE_ADDR_TRUTH, {16'h0, t});
  endtask : wtt

  // Inputs change on the edge, outputs judged at the falling edge
  task automatic drive(input logic [3:0] d);
    @(posedge pclk);
    data_in <= d;
    want <= lnk;
    @(negedge pclk);
  endtask : drive

  // Internal clock high for one cycle, low for at least one after
  task automatic step(input logic [3:0] d, input logic e);
    drive(d);
    @(posedge pclk);
    int_ctl.clk <= 1'b1;
    @(posedge pclk);
    int_ctl.clk <= 1'b0;
    @(negedge pclk);
    chk("q", route_out, e);
  endtask : step

  // Synced source: nothing after two edges, action at the third
  task automatic slow(input logic isclr, input logic e);
    @(posedge pclk);
    if (isclr) glb_ctl.clr <= 1'b1;
    else pin_ctl.pre <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("q early", route_out, !e);
    @(posedge pclk);
    glb_ctl.clr <= 1'b0;
    pin_ctl.pre <= 1'b0;
    @(negedge pclk);
    chk("q synced", route_out, e);
  endtask : slow

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, `PLE_ADDR_CTRL, 32'h0);
    chk("ctrl", rd, `PLE_CTRL_RST);
    apb(1'b1, `PLE_ADDR_TRUTH, 32'hFFFF_A5C3);
    apb(1'b0, `PLE_ADDR_TRUTH, 32'h0);
    chk("truth", rd, 32'h0000_A5C3);
    apb(1'b0, 12'h00C, 32'h0);
    chk("hole", rd, 32'h0);
    chk("slverr", err, 1'b1);
  endtask : t_regs

  task automatic t_comb;
    cfg = `PLE_CTRL_RST;
    wcfg;
    wtt(16'h6996);
    for (int i = 0; i < 16; i++) begin
      drive(i[3:0]);
      chk("local", local_out, tt[i]);
      chk("route", route_out, tt[i]);
    end
    cfg.route_sel = 1'b1;
    wcfg;
    drive(4'h1);
    chk("local", local_out, 1'b1);
    chk("route", route_out, 1'b0);
    // Status: table and comb high, register and carries low
    apb(1'b0, `PLE_ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0006);
  endtask : t_comb

  task automatic t_arith;
    logic [15:0] t;
    cfg = `PLE_CTRL_RST;
    cfg.mode = PLE_MODE_ARITH;
    wcfg;
    for (int k = 0; k < 8; k++) begin
      t[k] = ^k[2:0];
      t[8 + k] = (k[2] & k[1]) | (k[2] & k[0]) | (k[1] & k[0]);
    end
    wtt(t);
    for (int k = 0; k < 8; k++) begin
      lnk = '0;
      lnk.carry = k[0];
      drive({2'b00, k[1], k[2]});
      chk("sum", local_out, tt[k]);
      chk("carry", chain_out.carry, tt[8 + k]);
    end
    // Chain head ignores a carry arriving from below
    cfg.chain_start = 1'b1;
    wcfg;
    drive(4'h3);
    chk("sum head", local_out, 1'b0);
    cfg.chain_start = 1'b0;
    cfg.skip_in_sel = 1'b1;
    wcfg;
    lnk = '0;
    lnk.carry_skip = 1'b1;
    drive(4'h1);
    chk("sum skip", local_out, 1'b0);
    chk("carry skip", chain_out.carry, 1'b1);
    cfg.chain_end = 1'b1;
    wcfg;
    drive(4'h1);
    chk("carry end", chain_out.carry, 1'b0);
    chk("skip end", chain_out.carry_skip, 1'b0);
  endtask : t_arith

  task automatic t_casc;
    logic e;
    cfg = `PLE_CTRL_RST;
    cfg.casc_en = 1'b1;
    wtt(16'h8000);
    for (int a = 0; a < 2; a++) begin
      cfg.casc_and = a[0];
      wcfg;
      for (int k = 0; k < 4; k++) begin
        lnk = '0;
        lnk.cascade = k[0];
        e = a[0] ? (k[1] & k[0]) : (k[1] | k[0]);
        drive(k[1] ? 4'hF : 4'h0);
        chk("comb", local_out, e);
        chk("cascade", chain_out.cascade, e);
      end
    end
  endtask : t_casc

  // Table gives comb = third data input; register seen on route output
  task automatic t_ff;
    lnk = '0;
    cfg = `PLE_CTRL_RST;
    cfg.route_sel = 1'b1;
    cfg.clk_src = PLE_SRC_INTERN;
    cfg.clr_src = PLE_SRC_INTERN;
    cfg.pre_src = PLE_SRC_INTERN;
    wcfg;
    wtt(16'hF0F0);
    step(4'h4, 1'b1);
    step(4'h0, 1'b0);
    cfg.ena_use = 1'b1;
    wcfg;
    step(4'h4, 1'b0);
    step(4'h5, 1'b1);
    cfg.ena_use = 1'b0;
    cfg.ff_type = PLE_FF_T;
    wcfg;
    step(4'h4, 1'b0);
    step(4'h0, 1'b0);
    step(4'h4, 1'b1);
    cfg.ff_type = PLE_FF_JK;
    wcfg;
    step(4'h8, 1'b0);
    step(4'h4, 1'b1);
    step(4'hC, 1'b0);
    step(4'h0, 1'b0);
    cfg.ff_type = PLE_FF_SR;
    wcfg;
    step(4'h4, 1'b1);
    step(4'hC, 1'b1);
    step(4'h8, 1'b0);
    // Clear beats preset and a clock tick arriving together
    drive(4'h4);
    @(posedge pclk);
    int_ctl.pre <= 1'b1;
    @(posedge pclk);
    int_ctl <= 3'b111;
    @(posedge pclk);
    int_ctl <= 3'b000;
    @(negedge pclk);
    chk("q clear", route_out, 1'b0);
    cfg.pre_src = PLE_SRC_PIN;
    cfg.clr_src = PLE_SRC_GLOBAL;
    wcfg;
    slow(1'b0, 1'b1);
    slow(1'b1, 1'b0);
  endtask : t_ff

  task automatic t_cnt;
    cfg.mode = PLE_MODE_UPDN;
    wcfg;
    wtt(16'h6666);
    lnk.carry = 1'b1;
    step(4'h0, 1'b1);
    step(4'h0, 1'b0);
    step(4'hA, 1'b1);
    step(4'h8, 1'b0);
    step(4'hA, 1'b1);
    cfg.mode = PLE_MODE_CLRCNT;
    wcfg;
    step(4'h8, 1'b0);
  endtask : t_cnt

  // ----------------------------------------------------------------
  // Verdict and run control
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Whole run is about two dozen transfers; this bound leaves wide margin
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_comb();
    t_arith();
    t_casc();
    t_ff();
    t_cnt();
    conclude();
  end
endmodule : tb
